// ===== common/timer_io_pkg.sv
// Constants for the per-channel pin-function and event-flag block.
// Assumes a five-channel 16-bit timer whose counter logic sits outside.
package timer_io_pkg;
    // Channel count and special channels
    localparam int NUM_CH        = 5;
    localparam int CH_NO_TOGGLE  = 2;     // Toggle code drives 1 here
    localparam int CH_PHASE      = 2;     // Only up/down channel in phase mode
    localparam int CH_PAIR_LO    = 3;     // First channel of the PWM pair
    localparam int DMA_CH_COUNT  = 4;     // Channels 0..3 clear flag A by DMA

    // Register selector on the internal byte bus
    localparam logic SEL_PIN_FUNCTION = 1'h0;
    localparam logic SEL_EVENT_FLAGS  = 1'h1;

    // Reset values and read-only one bits
    localparam logic [7:0] PFC_RESET    = 8'h88;
    localparam logic [7:0] PFC_FIXED    = 8'h88;
    localparam logic [7:0] FLAGS_RESET  = 8'hF8;
    localparam logic [7:0] FLAGS_FIXED  = 8'hF8;
    localparam logic [7:0] UNMAPPED_VAL = 8'h00;

    // Field positions in pin_function_control
    localparam int A_FN_LSB = 0;
    localparam int B_FN_LSB = 4;

    // Flag positions in channel_event_flags
    localparam int FLAG_A    = 0;
    localparam int FLAG_B    = 1;
    localparam int FLAG_WRAP = 2;

    // Function field encodings
    localparam logic [2:0] FN_KEEP    = 3'h0;
    localparam logic [2:0] FN_DRIVE0  = 3'h1;
    localparam logic [2:0] FN_DRIVE1  = 3'h2;
    localparam logic [2:0] FN_TOGGLE  = 3'h3;
    localparam logic [2:0] FN_CAP_UP  = 3'h4;
    localparam logic [2:0] FN_CAP_DN  = 3'h5;
    localparam logic [2:0] FN_CAP_ALL = 3'h6;
    localparam logic [2:0] FN_NONE    = 3'h7;  // No compare, no capture, pin not driven
endpackage : timer_io_pkg

// ===== logic/timer_channel_io_and_status.sv
// Pin-function selection, compare/capture events and event flags
// for all five channels of the 16-bit timer unit.
// Assumes the counter and general registers live outside; pins are
// synchronous to clock; the CPU reaches both registers over a byte bus.
//
// What this block does
// - Five channels, two 8-bit registers each
// - Reset and standby load pin function 88h
// - Pin function bits 7,3 read one
// - B field 0xx selects compare pin action
// - B field 100/101/110 selects capture edge
// - A field mirrors B encodings
// - Channel 2 toggle code drives one
// - Compare pins stay zero until match
// - PWM pair mode ignores channel 3,4 settings
// - Reset and standby load flags F8h
// - Flag bits 7..3 read one
// - Only zero writes clear flags
// - Clear needs prior read while set
// - Wrap flag sets on up or down wrap
// - Underflow counts only in listed modes
// - Enabled set flags request interrupt
// - Match or capture sets flag A/B
// - DMA clears flag A, channels 0-3
// - Enable bits 2,1,0 gate wrap,B,A
`timescale 1ns/1ns
`default_nettype none
module timer_channel_io_and_status
    import timer_io_pkg::*;
(
    // Clock and reset
    input  wire  logic                        clock,
    input  wire  logic                        rst,
    input  wire  logic                        standby,
    // Internal byte bus
    input  wire  logic                        bus_read,
    input  wire  logic                        bus_write,
    input  wire  logic [2:0]                  bus_channel,
    input  wire  logic                        bus_select,
    input  wire  logic [7:0]                  bus_wdata,
    output var   logic [7:0]                  bus_rdata,
    output var   logic                        bus_rvalid,
    // Counter side
    input  wire  logic [NUM_CH-1:0][15:0]     channel_counter,
    input  wire  logic [NUM_CH-1:0][15:0]     general_reg_a,
    input  wire  logic [NUM_CH-1:0][15:0]     general_reg_b,
    input  wire  logic [NUM_CH-1:0]           count_up_wrap,
    input  wire  logic [NUM_CH-1:0]           count_down_wrap,
    // Mode inputs
    input  wire  logic                        phase_count_select,
    input  wire  logic                        combination_mode_bit1,
    input  wire  logic                        pwm_pair_mode,
    input  wire  logic [NUM_CH-1:0][2:0]      interrupt_enable_reg,
    input  wire  logic [DMA_CH_COUNT-1:0]     dma_clear_a,
    // Timer pins
    input  wire  logic [NUM_CH-1:0]           timer_pin_a_in,
    input  wire  logic [NUM_CH-1:0]           timer_pin_b_in,
    output var   logic [NUM_CH-1:0]           timer_pin_a_out,
    output var   logic [NUM_CH-1:0]           timer_pin_a_oe,
    output var   logic [NUM_CH-1:0]           timer_pin_b_out,
    output var   logic [NUM_CH-1:0]           timer_pin_b_oe,
    // Capture strobes and interrupt requests
    output var   logic [NUM_CH-1:0]           capture_a,
    output var   logic [NUM_CH-1:0]           capture_b,
    output var   logic [NUM_CH-1:0][2:0]      irq_request
);

    // Field is an output-compare selection
    function automatic logic fn_is_compare(input logic [2:0] fn);
        fn_is_compare = (fn[2] == 1'b0);
    endfunction : fn_is_compare

    // Selected edge seen on the sampled pin
    function automatic logic fn_capture_hit(input logic [2:0] fn,
                                            input logic       rise,
                                            input logic       fall);
        unique case (fn)
            FN_CAP_UP:  fn_capture_hit = rise;
            FN_CAP_DN:  fn_capture_hit = fall;
            FN_CAP_ALL: fn_capture_hit = rise | fall;
            default:    fn_capture_hit = 1'b0;   // Compare codes and 111
        endcase
    endfunction : fn_capture_hit

    // Pin level after a compare match
    function automatic logic fn_pin_next(input logic [2:0] fn,
                                         input logic       cur,
                                         input logic       no_toggle);
        unique case (fn)
            FN_DRIVE0: fn_pin_next = 1'b0;
            FN_DRIVE1: fn_pin_next = 1'b1;
            FN_TOGGLE: fn_pin_next = no_toggle ? 1'b1 : ~cur;
            default:   fn_pin_next = cur;
        endcase
    endfunction : fn_pin_next

    // Register storage, one of each per channel
    logic [NUM_CH-1:0][7:0] pfc_r;          // pin_function_control
    logic [NUM_CH-1:0][7:0] pfc_nxt;
    logic [NUM_CH-1:0][2:0] flags_r;        // Writable part of channel_event_flags
    logic [NUM_CH-1:0][2:0] flags_nxt;
    logic [NUM_CH-1:0][2:0] armed_r;        // Flag seen as one by a read
    logic [NUM_CH-1:0][2:0] armed_nxt;

    // Pin sampling and compare history
    logic [NUM_CH-1:0]      pin_a_prev_r;   // Last sampled A pin level
    logic [NUM_CH-1:0]      pin_b_prev_r;   // Last sampled B pin level
    logic [NUM_CH-1:0]      eq_a_prev_r;    // Counter equalled reg A last cycle
    logic [NUM_CH-1:0]      eq_b_prev_r;
    logic [NUM_CH-1:0]      pin_a_nxt;
    logic [NUM_CH-1:0]      pin_b_nxt;
    logic [NUM_CH-1:0]      oe_a_nxt;
    logic [NUM_CH-1:0]      oe_b_nxt;
    logic [NUM_CH-1:0]      cap_a_nxt;
    logic [NUM_CH-1:0]      cap_b_nxt;
    logic [NUM_CH-1:0][2:0] irq_nxt;

    // Bus decode
    wire        chan_ok    = (bus_channel < 3'(NUM_CH));
    wire [2:0]  chan_idx   = chan_ok ? bus_channel : 3'h0;
    wire [7:0]  pfc_view   = pfc_r[chan_idx] | PFC_FIXED;
    wire [7:0]  flags_view = FLAGS_FIXED | {5'h00, flags_r[chan_idx]};
    wire [7:0]  read_mux   = !chan_ok ? UNMAPPED_VAL :
                             (bus_select == SEL_EVENT_FLAGS) ? flags_view : pfc_view;

    // Per-channel event logic
    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++) begin : g_ch
            // Settings of the PWM pair are ignored while that mode runs
            wire override = (c >= CH_PAIR_LO) && pwm_pair_mode;
            // Idle code, not keep: keep is still a compare and would raise flags
            wire [2:0] fn_a = override ? FN_NONE : pfc_r[c][A_FN_LSB +: 3];
            wire [2:0] fn_b = override ? FN_NONE : pfc_r[c][B_FN_LSB +: 3];

            // Equality as a one-cycle event; a held count would otherwise
            // raise the flag again right after software clears it
            wire eq_a    = (channel_counter[c] == general_reg_a[c]);
            wire eq_b    = (channel_counter[c] == general_reg_b[c]);
            wire match_a = fn_is_compare(fn_a) && eq_a && !eq_a_prev_r[c];
            wire match_b = fn_is_compare(fn_b) && eq_b && !eq_b_prev_r[c];

            // Edges taken between two clocked samples of the pin
            wire rise_a  = timer_pin_a_in[c] && !pin_a_prev_r[c];
            wire fall_a  = !timer_pin_a_in[c] && pin_a_prev_r[c];
            wire rise_b  = timer_pin_b_in[c] && !pin_b_prev_r[c];
            wire fall_b  = !timer_pin_b_in[c] && pin_b_prev_r[c];
            wire hit_a   = fn_capture_hit(fn_a, rise_a, fall_a);
            wire hit_b   = fn_capture_hit(fn_b, rise_b, fall_b);

            // Underflow only in the modes that count down
            wire down_ok = (c == CH_PHASE && phase_count_select) ||
                           (c >= CH_PAIR_LO && combination_mode_bit1);
            wire wrap    = count_up_wrap[c] || (count_down_wrap[c] && down_ok);

            // Hardware set events per flag
            wire [2:0] set_evt = {wrap, match_b || hit_b, match_a || hit_a};

            // Bus strobes aimed at this channel
            wire hit_ch  = chan_ok && (bus_channel == 3'(c));
            wire wr_pfc  = bus_write && hit_ch && (bus_select == SEL_PIN_FUNCTION);
            wire wr_flg  = bus_write && hit_ch && (bus_select == SEL_EVENT_FLAGS);
            wire rd_flg  = bus_read  && hit_ch && (bus_select == SEL_EVENT_FLAGS);

            // Zero written over a flag that was read as one
            wire [2:0] sw_clr  = wr_flg ? (~bus_wdata[2:0] & armed_r[c]) : 3'h0;
            wire       dma_clr = (c < DMA_CH_COUNT) ? dma_clear_a[c] : 1'b0;
            wire [2:0] clr_all = sw_clr | {2'h0, dma_clr};
            wire [2:0] flg_next = (flags_r[c] & ~clr_all) | set_evt;

            // Register next values
            always_comb begin
                pfc_nxt[c] = wr_pfc ? ((bus_wdata & ~PFC_FIXED) | PFC_FIXED)
                                    : pfc_r[c];
                flags_nxt[c] = flg_next;
                // Arm on a read that sees one; drop once the flag is low
                armed_nxt[c] = (armed_r[c] | (rd_flg ? flags_r[c] : 3'h0))
                               & flg_next;
            end

            // Pin drive: only compare codes that act own the pin
            always_comb begin
                pin_a_nxt[c] = match_a ? fn_pin_next(fn_a, timer_pin_a_out[c],
                                                     c == CH_NO_TOGGLE)
                                       : timer_pin_a_out[c];
                pin_b_nxt[c] = match_b ? fn_pin_next(fn_b, timer_pin_b_out[c],
                                                     c == CH_NO_TOGGLE)
                                       : timer_pin_b_out[c];
                oe_a_nxt[c]  = fn_is_compare(fn_a) && (fn_a != FN_KEEP);
                oe_b_nxt[c]  = fn_is_compare(fn_b) && (fn_b != FN_KEEP);
                cap_a_nxt[c] = hit_a;
                cap_b_nxt[c] = hit_b;
                irq_nxt[c]   = flg_next & interrupt_enable_reg[c];
            end
        end
    endgenerate

    // Register file; standby reloads like reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pfc_r   <= {NUM_CH{PFC_RESET}};
            flags_r <= {NUM_CH{FLAGS_RESET[2:0]}};
            armed_r <= '0;
        end else if (standby) begin
            pfc_r   <= {NUM_CH{PFC_RESET}};
            flags_r <= {NUM_CH{FLAGS_RESET[2:0]}};
            armed_r <= '0;
        end else begin
            pfc_r   <= pfc_nxt;
            flags_r <= flags_nxt;
            armed_r <= armed_nxt;
        end
    end

    // Pin sampling and equality history
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_a_prev_r <= '0;
            pin_b_prev_r <= '0;
            eq_a_prev_r  <= '0;
            eq_b_prev_r  <= '0;
        end else begin
            pin_a_prev_r <= timer_pin_a_in;
            pin_b_prev_r <= timer_pin_b_in;
            eq_a_prev_r  <= channel_counter_eq(1'b0);
            eq_b_prev_r  <= channel_counter_eq(1'b1);
        end
    end

    // Equality of every channel against register A or B
    function automatic logic [NUM_CH-1:0] channel_counter_eq(input logic use_b);
        logic [NUM_CH-1:0] res;
        res = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            res[i] = use_b ? (channel_counter[i] == general_reg_b[i])
                           : (channel_counter[i] == general_reg_a[i]);
        end
        channel_counter_eq = res;
    endfunction : channel_counter_eq

    // Compare pins start low and hold until the first match
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timer_pin_a_out <= '0;
            timer_pin_b_out <= '0;
            timer_pin_a_oe  <= '0;
            timer_pin_b_oe  <= '0;
        end else if (standby) begin
            timer_pin_a_out <= '0;
            timer_pin_b_out <= '0;
            timer_pin_a_oe  <= '0;
            timer_pin_b_oe  <= '0;
        end else begin
            timer_pin_a_out <= pin_a_nxt;
            timer_pin_b_out <= pin_b_nxt;
            timer_pin_a_oe  <= oe_a_nxt;
            timer_pin_b_oe  <= oe_b_nxt;
        end
    end

    // Capture strobes land with the flag they set
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            capture_a <= '0;
            capture_b <= '0;
        end else begin
            capture_a <= cap_a_nxt;
            capture_b <= cap_b_nxt;
        end
    end

    // Interrupt requests follow the flags in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_request <= '0;
        end else if (standby) begin
            irq_request <= '0;
        end else begin
            irq_request <= irq_nxt;
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bus_rdata  <= '0;
            bus_rvalid <= 1'b0;
        end else begin
            bus_rdata  <= bus_read ? read_mux : bus_rdata;
            bus_rvalid <= bus_read;
        end
    end

endmodule : timer_channel_io_and_status
`default_nettype wire

// ===== tb/timer_channel_io_and_status_tb.sv
// Self-checking bench for the timer pin-function and event-flag block.
// Assumes the pin model and the bound checker are compiled with it.
`timescale 1ns/1ns
`default_nettype none
module timer_channel_io_and_status_tb
    import timer_io_pkg::*;
;
    // Design inputs
    logic clock = 1'h0, rst = 1'h1, standby = 1'h0, bus_read = 1'h0, bus_write = 1'h0;
    logic bus_select = 1'h0, phase_count_select = 1'h0, combination_mode_bit1 = 1'h0;
    logic pwm_pair_mode = 1'h0;
    logic [2:0] bus_channel = 3'h0;
    logic [7:0] bus_wdata = 8'h00, fl;
    logic [NUM_CH-1:0][15:0] channel_counter = '0;
    logic [NUM_CH-1:0][15:0] general_reg_a = '1, general_reg_b = '1;  // No match at start
    logic [NUM_CH-1:0] count_up_wrap = '0, count_down_wrap = '0, ext_a = '0, ext_b = '0;
    logic [NUM_CH-1:0][2:0] interrupt_enable_reg = '1;
    logic [DMA_CH_COUNT-1:0] dma_clear_a = '0;
    // Design outputs
    logic [7:0] bus_rdata;
    logic bus_rvalid;
    logic [NUM_CH-1:0] timer_pin_a_in, timer_pin_b_in, timer_pin_a_out, timer_pin_b_out;
    logic [NUM_CH-1:0] timer_pin_a_oe, timer_pin_b_oe, capture_a, capture_b;
    logic [NUM_CH-1:0][2:0] irq_request;
    int err_total = 0, compares = 0;
    // Compare case: channel, field B, code, pin after match 1 and 2, enable
    typedef struct packed {
        logic [2:0] ch;
        logic b;
        logic [2:0] code;
        logic p1, p2, oe;
    } row_type;
    row_type r;
    row_type rows [6] = '{'{3'h0, 1'h0, FN_DRIVE1, 1'h1, 1'h1, 1'h1},
        '{3'h0, 1'h0, FN_KEEP, 1'h1, 1'h1, 1'h0}, '{3'h0, 1'h0, FN_DRIVE0, 1'h0, 1'h0, 1'h1},
        '{3'h0, 1'h0, FN_TOGGLE, 1'h1, 1'h0, 1'h1}, '{3'h2, 1'h0, FN_TOGGLE, 1'h1, 1'h1, 1'h1},
        '{3'h1, 1'h1, FN_TOGGLE, 1'h1, 1'h0, 1'h1}};
    logic [2:0] wch [4] = '{3'h0, 3'h2, 3'h3, 3'h2};  // Down-wrap channels
    always #2 clock = ~clock;
    timer_channel_io_and_status DUT (.*);
    timer_pin_model pins (.ext_a, .ext_b, .out_a(timer_pin_a_out), .oe_a(timer_pin_a_oe),
        .out_b(timer_pin_b_out), .oe_b(timer_pin_b_oe), .pin_a(timer_pin_a_in),
        .pin_b(timer_pin_b_in));
    // Inputs change 1 ns after the edge, never on it
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask : tick
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    // Trailing idle cycle keeps strobes from being set twice in one step
    task automatic wr(input logic [2:0] ch, input logic sel, input logic [7:0] v);
        bus_channel = ch;
        bus_select = sel;
        bus_wdata = v;
        bus_write = 1'h1;
        tick(1);
        bus_write = 1'h0;
        tick(1);
    endtask : wr
    task automatic rc(input logic [2:0] ch, input logic sel, input logic [7:0] exp);
        bus_channel = ch;
        bus_select = sel;
        bus_read = 1'h1;
        tick(1);
        bus_read = 1'h0;
        chk("read valid", 8'h01, bus_rvalid);
        chk("read data", exp, bus_rdata);
        tick(1);
    endtask : rc
    task automatic all_reset_values(input string why);
        for (int c = 0; c < NUM_CH; c++) begin
            rc(3'(c), SEL_PIN_FUNCTION, PFC_RESET);
            rc(3'(c), SEL_EVENT_FLAGS, FLAGS_RESET);
        end
        $display("test %s done", why);
    endtask : all_reset_values
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // Hang guard counts as a mismatch
    initial begin
        #200000;
        err_total++;
        end_of_test();
    end
    initial begin
        tick(8);
        rst = 1'h0;
        all_reset_values("reset");
        foreach (rows[i]) begin
            r = rows[i];
            wr(r.ch, SEL_PIN_FUNCTION, PFC_FIXED | (8'(r.code) << (r.b ? B_FN_LSB : 0)));
            general_reg_a[r.ch] = r.b ? 16'h0020 : 16'h0010;
            general_reg_b[r.ch] = r.b ? 16'h0010 : 16'h0020;
            fl = r.b ? 8'hFA : 8'hF9;
            for (int k = 0; k < 2; k++) begin
                channel_counter[r.ch] = 16'h0010;
                tick(1);
                channel_counter[r.ch] = 16'h0000;
                chk("pin", k ? r.p2 : r.p1, r.b ? timer_pin_b_out[r.ch] : timer_pin_a_out[r.ch]);
                chk("irq", fl[2:0], irq_request[r.ch]);
                tick(1);
            end
            chk("oe", r.oe, r.b ? timer_pin_b_oe[r.ch] : timer_pin_a_oe[r.ch]);
            wr(r.ch, SEL_EVENT_FLAGS, 8'h00);
            rc(r.ch, SEL_EVENT_FLAGS, fl);
            wr(r.ch, SEL_EVENT_FLAGS, 8'hF8);
            rc(r.ch, SEL_EVENT_FLAGS, FLAGS_RESET);
        end
        $display("test rows done");
        // Capture codes: rising, falling, both
        for (int c = 4; c < 7; c++) begin
            wr(3'h0, SEL_PIN_FUNCTION, PFC_FIXED | 8'(c));
            ext_a[0] = 1'h1;
            tick(1);
            chk("capture rise", c != 5, capture_a[0]);
            tick(1);
            ext_a[0] = 1'h0;
            tick(1);
            chk("capture fall", c != 4, capture_a[0]);
            tick(1);
        end
        rc(3'h0, SEL_EVENT_FLAGS, 8'hF9);
        wr(3'h0, SEL_EVENT_FLAGS, 8'h00);
        // Capture on pin B, both-edge code, rising edge only
        wr(3'h0, SEL_PIN_FUNCTION, 8'hE8);
        ext_b[0] = 1'h1;
        tick(1);
        chk("capture b", 8'h01, capture_b[0]);
        rc(3'h0, SEL_EVENT_FLAGS, 8'hFA);
        wr(3'h0, SEL_EVENT_FLAGS, 8'h00);
        // Wrap up on channel 0, then down wraps under each mode
        count_up_wrap[0] = 1'h1;
        tick(1);
        count_up_wrap[0] = 1'h0;
        rc(3'h0, SEL_EVENT_FLAGS, 8'hFC);
        wr(3'h0, SEL_EVENT_FLAGS, 8'h00);
        for (int k = 0; k < 4; k++) begin
            phase_count_select = (k == 1);
            combination_mode_bit1 = (k == 2);
            count_down_wrap[wch[k]] = 1'h1;
            tick(1);
            count_down_wrap = '0;
            rc(wch[k], SEL_EVENT_FLAGS, (k == 1 || k == 2) ? 8'hFC : 8'hF8);
            wr(wch[k], SEL_EVENT_FLAGS, 8'h00);
        end
        // Flag A cleared by the DMA take
        wr(3'h0, SEL_PIN_FUNCTION, PFC_FIXED);
        general_reg_a[0] = 16'h0030;
        channel_counter[0] = 16'h0030;
        tick(1);
        channel_counter[0] = 16'h0000;
        dma_clear_a[0] = 1'h1;
        tick(1);
        dma_clear_a[0] = 1'h0;
        rc(3'h0, SEL_EVENT_FLAGS, FLAGS_RESET);
        // Pair mode hides channel 3 settings
        pwm_pair_mode = 1'h1;
        wr(3'h3, SEL_PIN_FUNCTION, 8'hAA);
        general_reg_a[3] = 16'h0040;
        channel_counter[3] = 16'h0040;
        tick(2);
        channel_counter[3] = 16'h0000;
        chk("pair pin", 8'h00, timer_pin_a_out[3]);
        rc(3'h3, SEL_EVENT_FLAGS, FLAGS_RESET);
        pwm_pair_mode = 1'h0;
        // Unmapped channel and fixed bits
        wr(3'h5, SEL_PIN_FUNCTION, 8'h77);
        rc(3'h5, SEL_PIN_FUNCTION, UNMAPPED_VAL);
        wr(3'h4, SEL_PIN_FUNCTION, 8'h00);
        rc(3'h4, SEL_PIN_FUNCTION, PFC_FIXED);
        wr(3'h4, SEL_EVENT_FLAGS, 8'hFF);
        rc(3'h4, SEL_EVENT_FLAGS, FLAGS_RESET);
        $display("test special cases done");
        wr(3'h4, SEL_PIN_FUNCTION, 8'hF7);
        standby = 1'h1;
        tick(1);
        standby = 1'h0;
        all_reset_values("standby");
        wr(3'h2, SEL_PIN_FUNCTION, 8'hF7);
        rst = 1'h1;
        tick(1);
        rst = 1'h0;
        all_reset_values("second reset");
        end_of_test();
    end
endmodule : timer_channel_io_and_status_tb
`default_nettype wire

// ===== tb/timer_io_props.sv
// Assertions on the timer pin-function and event-flag block.
// Bound to the block's top module; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module timer_io_props
    import timer_io_pkg::*;
(
    // Clock, reset, standby
    input wire logic clock,
    input wire logic rst,
    input wire logic standby,
    // Register bus
    input wire logic bus_read,
    input wire logic [2:0] bus_channel,
    input wire logic bus_select,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_rvalid,
    // Counter side and modes
    input wire logic [NUM_CH-1:0][15:0] channel_counter,
    input wire logic [NUM_CH-1:0][15:0] general_reg_a,
    input wire logic [NUM_CH-1:0] count_up_wrap,
    input wire logic pwm_pair_mode,
    input wire logic [NUM_CH-1:0][2:0] interrupt_enable_reg,
    // Pins and results
    input wire logic [NUM_CH-1:0] timer_pin_a_in,
    input wire logic [NUM_CH-1:0] timer_pin_a_out,
    input wire logic [NUM_CH-1:0] timer_pin_a_oe,
    input wire logic [NUM_CH-1:0] capture_a,
    input wire logic [NUM_CH-1:0][2:0] irq_request
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Up wrap on channel 0, wrap enable held over both cycles
    sequence wrap_enabled;
        count_up_wrap[0] && interrupt_enable_reg[0][2] && !standby
        ##1 interrupt_enable_reg[0][2] && !standby;
    endsequence
    // Pin A of channel 0 moved, standby not involved
    sequence pin_a_moved;
        !$stable(timer_pin_a_out[0]) && !standby && !$past(standby);
    endsequence
    AST_RVALID: assert property (bus_read |=> bus_rvalid)
        else $error("read not answered");
    AST_RD_UNMAPPED: assert property (
        bus_rvalid && $past(bus_channel) > 3'h4 |-> bus_rdata == UNMAPPED_VAL)
        else $error("unmapped read not zero");
    AST_RD_FIXED: assert property (
        bus_rvalid && $past(bus_channel) < 3'h5 |-> bus_rdata[7] && bus_rdata[3]
        && (!$past(bus_select) || &bus_rdata[7:3]))
        else $error("fixed one bits wrong");
    AST_PIN_MATCH: assert property (
        pin_a_moved |-> $past(channel_counter[0]) == $past(general_reg_a[0]))
        else $error("pin moved without match");
    AST_CAP_EDGE: assert property (
        capture_a[0] |-> $past(timer_pin_a_in[0]) != $past(timer_pin_a_in[0], 2))
        else $error("capture without pin edge");
    AST_PWM_PAIR: assert property (
        pwm_pair_mode [*2] |-> timer_pin_a_oe[4:3] == 2'h0 && capture_a[4:3] == 2'h0)
        else $error("pair channels still active");
    AST_WRAP_SET: assert property (wrap_enabled |-> irq_request[0][2])
        else $error("wrap did not request");
    AST_IRQ_GATE: assert property (
        (irq_request[0] & ~$past(interrupt_enable_reg[0])) == 3'h0)
        else $error("request without enable");
    AST_STANDBY: assert property (
        standby |=> timer_pin_a_out == '0 && irq_request == '0)
        else $error("standby did not clear");
endmodule : timer_io_props
bind timer_channel_io_and_status timer_io_props props (
    .clock, .rst, .standby, .bus_read, .bus_channel, .bus_select, .bus_rdata,
    .bus_rvalid, .channel_counter, .general_reg_a, .count_up_wrap, .pwm_pair_mode,
    .interrupt_enable_reg, .timer_pin_a_in, .timer_pin_a_out, .timer_pin_a_oe,
    .capture_a, .irq_request);
`default_nettype wire

// ===== tb/timer_pin_model.sv
// Model of the devices outside the timer pins.
// Assumes the bench sets outside levels; pins have no pull.
`timescale 1ns/1ns
`default_nettype none
module timer_pin_model
    import timer_io_pkg::*;
(
    // Outside levels
    input wire logic [NUM_CH-1:0] ext_a,
    input wire logic [NUM_CH-1:0] ext_b,
    // Block drive
    input wire logic [NUM_CH-1:0] out_a,
    input wire logic [NUM_CH-1:0] oe_a,
    input wire logic [NUM_CH-1:0] out_b,
    input wire logic [NUM_CH-1:0] oe_b,
    // Wire levels
    output var logic [NUM_CH-1:0] pin_a,
    output var logic [NUM_CH-1:0] pin_b
);
    // Driven pin shows the block, else the outside level
    assign pin_a = (oe_a & out_a) | (~oe_a & ext_a);
    assign pin_b = (oe_b & out_b) | (~oe_b & ext_b);
endmodule : timer_pin_model
`default_nettype wire
